// *** design/dcs_pkg.sv ***
package dcs_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_DEBUG_CONTROL_ONE = 12'h000;
  localparam logic [11:0] OFF_SEQ_NEXT = 12'h004;
  localparam logic [11:0] OFF_SEQ_ENABLE = 12'h008;
  localparam logic [11:0] OFF_DEBUG_STATUS = 12'h00C;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
  localparam logic [11:0] OFF_RANGE_CONTROL = 12'h018;
  localparam logic [11:0] OFF_RANGE_LOW = 12'h01C;
  localparam logic [11:0] OFF_RANGE_HIGH = 12'h020;
  localparam logic [11:0] OFF_COMPARATOR_D_CONTROL = 12'h140;
  localparam logic [11:0] OFF_COMPARATOR_D_ADDRESS = 12'h144;

  // ----------------------------------------------------------------
  // comparator control layout
  // ----------------------------------------------------------------
  localparam int unsigned CTL_PC_SELECT_BIT = 5;
  localparam int unsigned CTL_DIR_VALUE_BIT = 3;
  localparam int unsigned CTL_DIR_ENABLE_BIT = 2;
  localparam int unsigned CTL_ON_BIT = 0;
  localparam logic [7:0] CTL_IMPL_MASK = 8'h2D;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // debug_control_one layout
  // ----------------------------------------------------------------
  localparam int unsigned C1_ARM_BIT = 0;
  localparam int unsigned C1_BRK_ENABLE_BIT = 1;
  localparam int unsigned C1_TRIGGER_BIT = 2;
  localparam int unsigned C1_EEV_MODE_LSB = 4;
  localparam int unsigned C1_RANGE_MODE_BIT = 8;
  localparam logic [1:0] EEV_MODE_ADVANCE = 2'b10;

  // ----------------------------------------------------------------
  // sequencer configuration: per state, per event, 2-bit target
  // event order in each group: 3 external, 2 match d, 1 match b, 0 match a
  // ----------------------------------------------------------------
  localparam int unsigned EV_COUNT = 4;
  localparam int unsigned SEQ_CODE_W = 2;
  localparam int unsigned SEQ_STATE_STRIDE = 8;
  localparam logic [1:0] SEQ_CODE_FINAL = 2'h0;
  localparam logic [31:0] SEQ_NEXT_RESET = 32'h0000_0000;
  localparam logic [31:0] SEQ_ENABLE_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // state indication and interrupts
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {SEQ_IDLE, SEQ_FIRST, SEQ_SECOND, SEQ_THIRD, SEQ_FINAL} dcs_seq_t;
  localparam logic [2:0] SSF_FINAL = 3'h4;
  localparam int unsigned STATUS_ARMED_BIT = 3;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_BRK_BIT = 0;
  localparam int unsigned IRQ_HIT_BIT = 1;
  localparam int unsigned IRQ_END_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// *** design/dcs_comparator.sv ***
`timescale 1ns/1ns
module dcs_comparator
  import dcs_pkg::*;
#(
  parameter int unsigned AW = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] ctl,
  input wire logic range_mode,
  input wire logic [AW-1:0] match_addr,
  input wire logic [AW-1:0] range_low,
  input wire logic [AW-1:0] range_high,
  input wire logic bus_valid,
  input wire logic [AW-1:0] bus_addr,
  input wire logic bus_read,
  input wire logic exec_valid,
  input wire logic [AW-1:0] exec_pc,
  output logic hit_reg
);

  logic pc_sel;
  logic strobe;
  logic [AW-1:0] addr;
  logic dir_ok;
  logic addr_ok;
  logic hit_next;

  // ----------------------------------------------------------------
  // match condition
  // ----------------------------------------------------------------
  // pc matching is data independent, so direction plays no part there
  assign pc_sel = ctl[CTL_PC_SELECT_BIT];
  assign strobe = pc_sel ? exec_valid : bus_valid;
  assign addr = pc_sel ? exec_pc : bus_addr;
  assign dir_ok = pc_sel || !ctl[CTL_DIR_ENABLE_BIT] ||
                  (bus_read == ctl[CTL_DIR_VALUE_BIT]);
  assign addr_ok = range_mode ? (addr >= range_low && addr <= range_high)
                              : (addr == match_addr);
  assign hit_next = ctl[CTL_ON_BIT] && strobe && dir_ok && addr_ok;

  // one-cycle hit pulse the cycle after the qualifying access
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= hit_next;
    end
  end

endmodule

// *** design/dcs_debug_compare_sequencer.sv ***
`timescale 1ns/1ns
module dcs_debug_compare_sequencer
  import dcs_pkg::*;
#(
  parameter int unsigned AW = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // processor core
  input wire logic bus_valid,
  input wire logic [AW-1:0] bus_addr,
  input wire logic bus_read,
  input wire logic exec_valid,
  input wire logic [AW-1:0] exec_pc,
  input wire logic comparator_a_hit,
  input wire logic comparator_b_hit,
  input wire logic external_event_input,
  output logic breakpoint_request,
  output logic comparator_d_hit,
  output logic irq
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // offset is one of the mapped words
  function automatic logic mapped(input logic [11:0] a);
    return a == OFF_DEBUG_CONTROL_ONE || a == OFF_SEQ_NEXT || a == OFF_SEQ_ENABLE ||
           a == OFF_DEBUG_STATUS || a == OFF_IRQ_STATUS || a == OFF_IRQ_MASK ||
           a == OFF_RANGE_CONTROL || a == OFF_RANGE_LOW || a == OFF_RANGE_HIGH ||
           a == OFF_COMPARATOR_D_CONTROL || a == OFF_COMPARATOR_D_ADDRESS;
  endfunction

  // state flag encoding of a sequencer state
  function automatic logic [2:0] ssf_of(input dcs_seq_t s);
    logic [2:0] v;
    v = 3'h0;
    case (s)
      SEQ_FIRST: v = 3'h1;
      SEQ_SECOND: v = 3'h2;
      SEQ_THIRD: v = 3'h3;
      SEQ_FINAL: v = SSF_FINAL;
      default: v = 3'h0;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // registers and nets
  // ----------------------------------------------------------------
  logic aw_held_reg;
  logic [11:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic brk_enable_reg;
  logic [1:0] eev_mode_reg;
  logic range_mode_reg;
  logic [31:0] seq_next_reg;
  logic [31:0] seq_enable_reg;
  logic [7:0] cmpd_ctl_reg;
  logic [AW-1:0] cmpd_addr_reg;
  logic [7:0] range_ctl_reg;
  logic [AW-1:0] range_low_reg;
  logic [AW-1:0] range_high_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic ext_prev_reg;
  logic brk_reg;
  dcs_seq_t state_reg;

  logic wr_fire;
  logic [31:0] wr_word;
  logic c1_write;
  logic arm_set;
  logic arm_clear;
  logic trigger;
  logic armed;
  logic ext_event;
  logic [EV_COUNT-1:0] events;
  logic [EV_COUNT-1:0] enabled_events;
  logic [1:0] ev_code;
  logic ev_any;
  logic seq_end;
  logic [7:0] eff_ctl;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clear;
  logic [31:0] rd_word;

  assign armed = state_reg != SEQ_IDLE;

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  // address and data are parked independently; one write is in flight at a time
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign wr_fire = aw_held_reg && w_held_reg;

  // capture address and data, then respond one cycle after both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // read mux; comparator control reads back at any time, unused bits as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case ({s_axi_araddr[11:2], 2'b00})
      OFF_DEBUG_CONTROL_ONE: begin
        rd_word[C1_ARM_BIT] = armed;
        rd_word[C1_BRK_ENABLE_BIT] = brk_enable_reg;
        rd_word[C1_EEV_MODE_LSB +: 2] = eev_mode_reg;
        rd_word[C1_RANGE_MODE_BIT] = range_mode_reg;
      end
      OFF_SEQ_NEXT: rd_word = seq_next_reg;
      OFF_SEQ_ENABLE: rd_word = seq_enable_reg;
      OFF_DEBUG_STATUS: begin
        rd_word[2:0] = ssf_of(state_reg);
        rd_word[STATUS_ARMED_BIT] = armed;
      end
      OFF_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_status_reg;
      OFF_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask_reg;
      OFF_RANGE_CONTROL: rd_word[7:0] = range_ctl_reg;
      OFF_RANGE_LOW: rd_word[AW-1:0] = range_low_reg;
      OFF_RANGE_HIGH: rd_word[AW-1:0] = range_high_reg;
      OFF_COMPARATOR_D_CONTROL: rd_word[7:0] = cmpd_ctl_reg;
      OFF_COMPARATOR_D_ADDRESS: rd_word[AW-1:0] = cmpd_addr_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read data registered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= mapped({s_axi_araddr[11:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  assign wr_word = merge(32'h0000_0000, w_data_reg, w_strb_reg);
  assign c1_write = wr_fire && aw_addr_reg == OFF_DEBUG_CONTROL_ONE && w_strb_reg[0];
  assign arm_set = c1_write && wr_word[C1_ARM_BIT];
  assign arm_clear = c1_write && !wr_word[C1_ARM_BIT];
  assign trigger = c1_write && wr_word[C1_TRIGGER_BIT];

  // global control, writable at any time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brk_enable_reg <= 1'b0;
      eev_mode_reg <= 2'b00;
      range_mode_reg <= 1'b0;
      seq_next_reg <= SEQ_NEXT_RESET;
      seq_enable_reg <= SEQ_ENABLE_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
    end else if (wr_fire) begin
      if (c1_write) begin
        brk_enable_reg <= wr_word[C1_BRK_ENABLE_BIT];
        eev_mode_reg <= wr_word[C1_EEV_MODE_LSB +: 2];
      end
      if (aw_addr_reg == OFF_DEBUG_CONTROL_ONE && w_strb_reg[1]) begin
        range_mode_reg <= wr_word[C1_RANGE_MODE_BIT];
      end
      if (aw_addr_reg == OFF_SEQ_NEXT) begin
        seq_next_reg <= merge(seq_next_reg, w_data_reg, w_strb_reg);
      end
      if (aw_addr_reg == OFF_SEQ_ENABLE) begin
        seq_enable_reg <= merge(seq_enable_reg, w_data_reg, w_strb_reg);
      end
      if (aw_addr_reg == OFF_IRQ_MASK && w_strb_reg[0]) begin
        irq_mask_reg <= wr_word[IRQ_W-1:0];
      end
    end
  end

  // comparator setup is frozen while armed; range mode in debug_control_one stays writable and can still switch matching
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmpd_ctl_reg <= CTL_RESET;
      cmpd_addr_reg <= '0;
      range_ctl_reg <= CTL_RESET;
      range_low_reg <= '0;
      range_high_reg <= '0;
    end else if (wr_fire && !armed) begin
      if (aw_addr_reg == OFF_COMPARATOR_D_CONTROL && w_strb_reg[0]) begin
        cmpd_ctl_reg <= wr_word[7:0] & CTL_IMPL_MASK;
      end
      if (aw_addr_reg == OFF_COMPARATOR_D_ADDRESS) begin
        cmpd_addr_reg <= AW'(merge(32'(cmpd_addr_reg), w_data_reg, w_strb_reg));
      end
      if (aw_addr_reg == OFF_RANGE_CONTROL && w_strb_reg[0]) begin
        range_ctl_reg <= wr_word[7:0] & CTL_IMPL_MASK;
      end
      if (aw_addr_reg == OFF_RANGE_LOW) begin
        range_low_reg <= AW'(merge(32'(range_low_reg), w_data_reg, w_strb_reg));
      end
      if (aw_addr_reg == OFF_RANGE_HIGH) begin
        range_high_reg <= AW'(merge(32'(range_high_reg), w_data_reg, w_strb_reg));
      end
    end
  end

  // ----------------------------------------------------------------
  // comparator d
  // ----------------------------------------------------------------
  // range mode hands the comparison over to the pair's range setup
  assign eff_ctl = range_mode_reg ? range_ctl_reg : cmpd_ctl_reg;

  dcs_comparator #(
    .AW(AW)
  ) u_cmpd (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctl(eff_ctl),
    .range_mode(range_mode_reg),
    .match_addr(cmpd_addr_reg),
    .range_low(range_low_reg),
    .range_high(range_high_reg),
    .bus_valid(bus_valid),
    .bus_addr(bus_addr),
    .bus_read(bus_read),
    .exec_valid(exec_valid),
    .exec_pc(exec_pc),
    .hit_reg(comparator_d_hit)
  );

  // ----------------------------------------------------------------
  // event selection
  // ----------------------------------------------------------------
  // external input counts on its rising edge only, and only in the advance mode
  assign ext_event = external_event_input && !ext_prev_reg &&
                     eev_mode_reg == EEV_MODE_ADVANCE;
  assign events = {ext_event, comparator_d_hit, comparator_b_hit, comparator_a_hit};

  // pick the highest-priority enabled event and its configured target
  always_comb begin
    enabled_events = 4'h0;
    ev_code = SEQ_CODE_FINAL;
    ev_any = 1'b0;
    case (state_reg)
      SEQ_FIRST: enabled_events = events & seq_enable_reg[0 +: EV_COUNT];
      SEQ_SECOND: enabled_events = events & seq_enable_reg[SEQ_STATE_STRIDE +: EV_COUNT];
      SEQ_THIRD: enabled_events = events & seq_enable_reg[2*SEQ_STATE_STRIDE +: EV_COUNT];
      default: enabled_events = 4'h0;
    endcase
    for (int i = 0; i < EV_COUNT; i++) begin
      if (enabled_events[i]) begin // later iterations hold higher priority
        ev_any = 1'b1;
        ev_code = seq_next_reg[(ssf_of(state_reg) - 3'h1) * SEQ_STATE_STRIDE
                               + i * SEQ_CODE_W +: SEQ_CODE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // state sequencer
  // ----------------------------------------------------------------
  assign seq_end = state_reg == SEQ_FINAL;

  // disarm wins over everything except in final; final always drops straight back to idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SEQ_IDLE;
      brk_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= external_event_input;
      brk_reg <= 1'b0;
      if (arm_clear && state_reg != SEQ_FINAL) begin
        state_reg <= SEQ_IDLE;
      end else begin
        case (state_reg)
          SEQ_IDLE: begin
            if (arm_set) begin
              state_reg <= SEQ_FIRST;
            end
          end
          SEQ_FIRST, SEQ_SECOND, SEQ_THIRD: begin
            if (trigger) begin
              state_reg <= SEQ_FINAL;
            end else if (ev_any) begin
              case (ev_code)
                2'h1: state_reg <= SEQ_FIRST;
                2'h2: state_reg <= SEQ_SECOND;
                2'h3: state_reg <= SEQ_THIRD;
                default: state_reg <= SEQ_FINAL;
              endcase
            end
          end
          SEQ_FINAL: begin
            state_reg <= SEQ_IDLE;
            brk_reg <= brk_enable_reg;
          end
          default: state_reg <= SEQ_IDLE;
        endcase
      end
    end
  end

  assign breakpoint_request = brk_reg;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign irq_set = {seq_end, comparator_d_hit, seq_end && brk_enable_reg};
  assign irq_clear = (wr_fire && aw_addr_reg == OFF_IRQ_STATUS && w_strb_reg[0]) ?
                     wr_word[IRQ_W-1:0] : '0;

  // sticky flags, a new event in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_set;
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

endmodule

// *** dv/dcs_props.sv ***
`timescale 1ns/1ns
module dcs_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_valid,
  input wire logic exec_valid,
  input wire logic comparator_d_hit,
  input wire logic breakpoint_request,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  // events are one-cycle pulses, bus answers come with fixed latency
  a_hit_pulse: assert property (comparator_d_hit |=> !comparator_d_hit)
    else $error("hit longer than one cycle");
  a_hit_cause: assert property (comparator_d_hit |-> $past(bus_valid) || $past(exec_valid))
    else $error("hit without access");
  a_brk_pulse: assert property (breakpoint_request |=> !breakpoint_request)
    else $error("breakpoint longer than one cycle");
  a_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  a_r_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  a_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  c_brk: cover property (breakpoint_request);
  c_hit: cover property (comparator_d_hit);
  c_irq: cover property (irq);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind dcs_debug_compare_sequencer dcs_props i_dcs_props (.*);

// *** dv/dcs_core_model.sv ***
`timescale 1ns/1ns
module dcs_core_model (
  input wire logic aclk,
  output logic bus_valid,
  output logic [23:0] bus_addr,
  output logic bus_read,
  output logic exec_valid,
  output logic [23:0] exec_pc,
  output logic comparator_a_hit,
  output logic comparator_b_hit,
  output logic external_event_input
);
  // ------------------------------------------------
  // core side
  // ------------------------------------------------
  // other comparators stay quiet in this bench
  initial begin
    bus_valid = 0;
    bus_addr = 0;
    bus_read = 0;
    exec_valid = 0;
    exec_pc = 0;
    comparator_a_hit = 0;
    comparator_b_hit = 0;
    external_event_input = 0;
  end
  // one-cycle access; lines show the inverse afterwards so stale values never match
  task access(input logic [23:0] a, input logic rd, input logic pc);
    @(posedge aclk);
    if (pc) begin
      exec_valid <= 1;
      exec_pc <= a;
    end else begin
      bus_valid <= 1;
      bus_addr <= a;
      bus_read <= rd;
    end
    @(posedge aclk);
    bus_valid <= 0;
    exec_valid <= 0;
    bus_addr <= ~a;
    exec_pc <= ~a;
    bus_read <= ~rd;
  endtask
  // level held two cycles, the design looks for its rising edge
  task ext_pulse();
    @(posedge aclk);
    external_event_input <= 1;
    repeat (2) @(posedge aclk);
    external_event_input <= 0;
  endtask
endmodule

// *** dv/test_debug_compare_sequencer.sv ***
`timescale 1ns/1ns
module test_debug_compare_sequencer;
  import dcs_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic bus_valid, bus_read, exec_valid, comparator_a_hit, comparator_b_hit;
  logic external_event_input, breakpoint_request, comparator_d_hit, irq;
  logic [23:0] bus_addr, exec_pc;
  logic [7:0] ct [8] = '{8'h00, 8'h01, 8'h05, 8'h0D, 8'h09, 8'h20, 8'h25, 8'h2D};
  logic [2:0] ex [8] = '{3'h0, 3'h6, 3'h4, 3'h2, 3'h6, 3'h0, 3'h1, 3'h1};
  int n_errors = 0, cmp_count = 0, n_brk = 0, b0;
  dcs_debug_compare_sequencer i_dcs_debug_compare_sequencer (.*);
  dcs_core_model i_dcs_core_model (.*);
  // 250 MHz clock
  always #2 aclk = ~aclk;
  // breakpoint pulses counted at the edge, before the design updates
  always @(posedge aclk) if (breakpoint_request === 1'b1) n_brk <= n_brk + 1;
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // readies are sampled at the falling edge, where they have settled
  task wr(input logic [11:0] a, input logic [31:0] d);
    int t;
    logic aw, w;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (t = 0; t < 40; t++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      last_resp = s_axi_bresp;
      if (s_axi_bvalid === 1'b1) break;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end
    @(posedge aclk);
    s_axi_bready <= 0;
    chk(32'(t == 40), 0);
    // one idle edge so the next call never drives bready twice in one step
    @(posedge aclk);
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    int t;
    logic ar;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (t = 0; t < 40; t++) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      if (s_axi_rvalid === 1'b1) break;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 0;
    end
    last_resp = s_axi_rresp;
    chk(s_axi_rdata, e);
    @(posedge aclk);
    s_axi_rready <= 0;
    chk(32'(t == 40), 0);
    @(posedge aclk);
  endtask
  task probe(input logic [23:0] a, input logic rd, input logic pc, input logic e);
    i_dcs_core_model.access(a, rd, pc);
    @(negedge aclk);
    chk(32'(comparator_d_hit), 32'(e));
    @(posedge aclk);
  endtask
  task wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task s_reset_regs();
    chk(32'({breakpoint_request, comparator_d_hit, irq}), 0);
    rchk(OFF_DEBUG_STATUS, 0);
    rchk(OFF_COMPARATOR_D_CONTROL, 0);
    wr(OFF_COMPARATOR_D_CONTROL, 32'h0000_00FF);
    rchk(OFF_COMPARATOR_D_CONTROL, 32'h0000_002D);
    rchk(12'hFFC, 0);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    wr(12'hFFC, 1);
    chk(32'(last_resp), 32'(RESP_SLVERR));
  endtask
  // eight control combinations against write, read and fetch at the match address
  task s_compare();
    wr(OFF_COMPARATOR_D_ADDRESS, 32'h0000_1234);
    for (int i = 0; i < 8; i++) begin
      wr(OFF_COMPARATOR_D_CONTROL, {24'h0, ct[i]});
      probe(24'h00_1234, 1'b0, 1'b0, ex[i][2]);
      probe(24'h00_1234, 1'b1, 1'b0, ex[i][1]);
      probe(24'h00_1234, 1'b0, 1'b1, ex[i][0]);
    end
    probe(24'h00_1235, 1'b0, 1'b1, 1'b0);
  endtask
  task s_range();
    wr(OFF_RANGE_CONTROL, 1);
    wr(OFF_RANGE_LOW, 32'h0000_2000);
    wr(OFF_RANGE_HIGH, 32'h0000_2004);
    wr(OFF_COMPARATOR_D_CONTROL, 0);
    wr(OFF_DEBUG_CONTROL_ONE, 32'h0000_0100);
    probe(24'h00_2004, 1'b1, 1'b0, 1'b1);
    probe(24'h00_2005, 1'b1, 1'b0, 1'b0);
    wr(OFF_DEBUG_CONTROL_ONE, 0);
  endtask
  // state one: hit goes to final, external event goes to state two
  task s_sequence();
    wr(OFF_COMPARATOR_D_CONTROL, 1);
    wr(OFF_IRQ_MASK, 1);
    wr(OFF_SEQ_NEXT, 32'h0000_0080);
    wr(OFF_SEQ_ENABLE, 32'h0000_000C);
    b0 = n_brk;
    wr(OFF_DEBUG_CONTROL_ONE, 3);
    rchk(OFF_DEBUG_STATUS, 9);
    wr(OFF_COMPARATOR_D_CONTROL, 0);
    rchk(OFF_COMPARATOR_D_CONTROL, 1);
    i_dcs_core_model.ext_pulse();
    rchk(OFF_DEBUG_STATUS, 9);
    wr(OFF_DEBUG_CONTROL_ONE, 2);
    rchk(OFF_DEBUG_STATUS, 0);
    chk(n_brk, b0);
    wr(OFF_DEBUG_CONTROL_ONE, 3);
    probe(24'h00_1234, 1'b0, 1'b0, 1'b1);
    // final stands for one cycle right after the hit; read once it is gone
    @(posedge aclk);
    rchk(OFF_DEBUG_STATUS, 0);
    chk(n_brk, b0 + 1);
    chk(32'(irq), 1);
    wr(OFF_IRQ_STATUS, 7);
    chk(32'(irq), 0);
    wr(OFF_DEBUG_CONTROL_ONE, 32'h0000_0023);
    i_dcs_core_model.ext_pulse();
    rchk(OFF_DEBUG_STATUS, 32'h0000_000A);
    wr(OFF_DEBUG_CONTROL_ONE, 32'h0000_0027);
    rchk(OFF_DEBUG_STATUS, 0);
    chk(n_brk, b0 + 2);
  endtask
  // ------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    s_reset_regs();
    s_compare();
    s_range();
    s_sequence();
    wrap_up();
  end
  // the whole run takes a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    chk(32'h0000_0001, 32'h0000_0000);
    wrap_up();
  end
endmodule
